/* File: design/timer16_pkg.sv */
// Purpose: constants, types and register layout of the 16-bit timer channel
// Assumes: APB3-style slave, 32-bit data, one register per aligned word
// Notes: package only, shared by the timer and its helper modules
// Functional notes
// - event mode: each rising edge of the count input advances the counter by one
// - software capture copies the counter into capture register a; count read there
// - pulse mode toggles the output flop on matches with compare a and b
// - pulse polarity follows the output flop value held before counting starts
// - with buffering on, compare a loads from its buffer on a compare b match
// - compare b sets the period, compare a the duty point
// - clearing run and buffer enable stops the counter and ends buffering
// - both match toggle enables set toggle the flop on either match
// - the clear code written to the flop control field forces the flop to 0
// - a compare b match raises the compare b interrupt
// - one-shot: free-running counter, trigger rising edge latches capture a
// - with its enable set, a capture into capture a toggles the flop
// - flop control field: 00 toggle, 01 set, 10 clear, 11 none; reads 11
// - a software capture also toggles the flop when capture toggling is enabled
package timer16_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_RUN  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MOD  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FFCR = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RGA  = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_RGB  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CPA  = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h18;

  // run register fields
  localparam int RUN_BIT  = 0;
  localparam int PRUN_BIT = 2;
  localparam int RDE_BIT  = 7;

  // mode register fields
  localparam int MOD_CLK_LSB   = 0;
  localparam int MOD_CLE_BIT   = 2;
  localparam int MOD_CPM_LSB   = 3;
  localparam int MOD_SWCAP_BIT = 5;

  // flop control register fields
  localparam int FFCR_CTL_LSB = 0;
  localparam int FFCR_EA_BIT  = 2;
  localparam int FFCR_EB_BIT  = 3;
  localparam int FFCR_CAP_BIT = 4;

  // read-back constants and reset values
  localparam logic [7:0]       FFCR_RD_FIXED = 8'hC3;
  localparam logic [CNT_W-1:0] CNT_RST       = 16'h0000;
  localparam logic [1:0]       CLK_RST       = 2'h0;
  localparam logic [1:0]       CPM_RST       = 2'h0;

  // prescaler: three taps at /2, /8, /32
  localparam int PRE_W = 5;

  typedef enum logic [1:0] {
    CLK_EXT = 2'b00,
    CLK_T1  = 2'b01,
    CLK_T4  = 2'b10,
    CLK_T16 = 2'b11
  } clk_sel_e;

  typedef enum logic [1:0] {
    FF_TOGGLE = 2'b00,
    FF_SET    = 2'b01,
    FF_CLEAR  = 2'b10,
    FF_HOLD   = 2'b11
  } ff_ctl_e;

  typedef enum logic [1:0] {
    CAP_OFF  = 2'b00,
    CAP_RISE = 2'b01,
    CAP_RSV2 = 2'b10,
    CAP_RSV3 = 2'b11
  } cap_trig_e;

  typedef enum logic {
    APB_WAIT = 1'b0,
    APB_DONE = 1'b1
  } apb_st_e;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;

endpackage

/* File: design/input_edge_sync.sv */
// Purpose: bring an external pin into the clock domain and find rising edges
// Assumes: pin may change at any time
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module input_edge_sync
  import timer16_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      level,
  output logic      rise
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // two-flop synchroniser plus one delay stage for the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // edge seen on synchronised samples only
  assign level = sync_ff;
  assign rise  = sync_ff & ~prev_ff;
endmodule

/* File: design/timer_prescaler.sv */
// Purpose: free-running divider giving count ticks at three rates
// Assumes: run held high while the channel counts
// Notes: ticks are one-cycle pulses; divider clears when stopped
`timescale 1ns/1ps
module timer_prescaler
  import timer16_pkg::*;
#(
  parameter int W = PRE_W
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  output logic      [2:0] tick
);
  logic [W-1:0] div_ff;

  // divider advances only while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= '0;
    end else if (run) begin
      div_ff <= div_ff + 1'b1;
    end else begin
      div_ff <= '0;
    end
  end

  // tap i fires when the low 2*i+1 bits wrap
  for (genvar i = 0; i < 3; i++) begin : g_tap
    assign tick[i] = run & (&div_ff[2*i:0]);
  end
endmodule

/* File: design/timer16_event_ppg_oneshot.sv */
// Purpose: 16-bit timer channel with event count, pulse and one-shot modes
// Assumes: APB master per protocol; pins sampled through synchronisers
// Notes: one wait state on every APB access; irq outputs are one-cycle pulses
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module timer16_event_ppg_oneshot
  import timer16_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire apb_req_s          apb_req,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ext_count_trigger_in,
  output logic                   pulse_output_pin,
  output logic                   compare_a_irq,
  output logic                   compare_b_irq,
  output logic                   capture_a_irq
);

  // register state
  logic             run_ff;
  logic             prescaler_run_bit_ff;
  logic             rde_ff;
  clk_sel_e         clk_sel_ff;
  logic             clr_en_ff;
  cap_trig_e        cap_trig_ff;
  logic             en_a_ff;
  logic             en_b_ff;
  logic             en_cap_ff;
  logic [CNT_W-1:0] up_counter_ff;
  logic [CNT_W-1:0] compare_reg_a_ff;
  logic [CNT_W-1:0] buffer_a_ff;
  logic [CNT_W-1:0] compare_reg_b_ff;
  logic [CNT_W-1:0] capture_reg_a_ff;
  logic             output_flipflop_ff;
  logic             moved_ff;
  logic             clr_pend_ff;
  apb_st_e          apb_st_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic             pslverr_ff;
  logic             irq_a_ff;
  logic             irq_b_ff;
  logic             irq_cap_ff;

  // combinational helpers
  logic             pin_level;
  logic             pin_rise;
  logic [2:0]       pre_tick;
  logic             count_tick;
  logic             match_a;
  logic             match_b;
  logic             hw_cap;
  logic             sw_cap;
  logic             capture_now;
  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;
  logic [7:0]       wb;
  logic [CNT_W-1:0] wh;
  logic [DATA_W-1:0] nxt_prdata;
  logic             nxt_ff;
  logic             toggle_req;
  ff_ctl_e          ff_cmd;

  // true for an offset that holds a register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == REG_RUN) || (a == REG_MOD) || (a == REG_FFCR) ||
           (a == REG_RGA) || (a == REG_RGB) || (a == REG_CPA) ||
           (a == REG_STAT);
  endfunction

  // widen a 16-bit value to a bus word
  function automatic logic [DATA_W-1:0] word16(input logic [CNT_W-1:0] v);
    return {{(DATA_W-CNT_W){1'b0}}, v};
  endfunction

  // widen an 8-bit value to a bus word
  function automatic logic [DATA_W-1:0] word8(input logic [7:0] v);
    return {{(DATA_W-8){1'b0}}, v};
  endfunction

  // count and trigger pin shares one synchroniser
  input_edge_sync u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (ext_count_trigger_in),
    .level   (pin_level),
    .rise    (pin_rise)
  );

  // prescaler runs only with both run bits set
  timer_prescaler #(
    .W (PRE_W)
  ) u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run_ff & prescaler_run_bit_ff),
    .tick    (pre_tick)
  );

  // APB decode: a write takes effect at the completing edge; read data is taken one edge earlier
  assign addr_ok = is_mapped(apb_req.paddr);
  assign wr_en   = apb_req.psel & apb_req.penable & (apb_st_ff == APB_DONE)
                   & apb_req.pwrite & addr_ok;
  assign rd_en   = apb_req.psel & apb_req.penable & (apb_st_ff == APB_DONE)
                   & ~apb_req.pwrite;
  assign wb      = apb_req.pwdata[7:0];
  assign wh      = apb_req.pwdata[CNT_W-1:0];

  // counting clock: external edges need the prescaler run bit as well
  always_comb begin
    count_tick = 1'b0;
    if (run_ff && prescaler_run_bit_ff) begin
      unique case (clk_sel_ff)
        CLK_EXT: count_tick = pin_rise;
        CLK_T1:  count_tick = pre_tick[0];
        CLK_T4:  count_tick = pre_tick[1];
        CLK_T16: count_tick = pre_tick[2];
      endcase
    end
  end

  // a match counts once, in the first cycle the counter holds the value
  assign match_a = run_ff & moved_ff & (up_counter_ff == compare_reg_a_ff);
  assign match_b = run_ff & moved_ff & (up_counter_ff == compare_reg_b_ff);

  // capture sources: trigger pin edge or software command
  assign hw_cap = run_ff & (cap_trig_ff == CAP_RISE) & pin_rise;
  assign sw_cap = wr_en & (apb_req.paddr == REG_MOD) & ~wb[MOD_SWCAP_BIT];
  assign capture_now = hw_cap | sw_cap;

  // APB handshake: one wait state, then ready with data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_st_ff <= APB_WAIT;
    end else begin
      unique case (apb_st_ff)
        APB_WAIT: begin
          if (apb_req.psel && apb_req.penable) begin
            apb_st_ff <= APB_DONE;
          end
        end
        APB_DONE: apb_st_ff <= APB_WAIT;
      endcase
    end
  end

  // read mux; the flop control field always reads as its no-op code
  always_comb begin
    nxt_prdata = '0;
    unique case (apb_req.paddr)
      REG_RUN: begin
        nxt_prdata[RUN_BIT]  = run_ff;
        nxt_prdata[PRUN_BIT] = prescaler_run_bit_ff;
        nxt_prdata[RDE_BIT]  = rde_ff;
      end
      REG_MOD: begin
        nxt_prdata[MOD_CLK_LSB +: 2] = clk_sel_ff;
        nxt_prdata[MOD_CLE_BIT]      = clr_en_ff;
        nxt_prdata[MOD_CPM_LSB +: 2] = cap_trig_ff;
        nxt_prdata[MOD_SWCAP_BIT]    = 1'b1;
      end
      REG_FFCR: begin
        nxt_prdata = word8(FFCR_RD_FIXED);
        nxt_prdata[FFCR_EA_BIT]  = en_a_ff;
        nxt_prdata[FFCR_EB_BIT]  = en_b_ff;
        nxt_prdata[FFCR_CAP_BIT] = en_cap_ff;
      end
      REG_RGA:  nxt_prdata = word16(compare_reg_a_ff);
      REG_RGB:  nxt_prdata = word16(compare_reg_b_ff);
      REG_CPA:  nxt_prdata = word16(capture_reg_a_ff);
      REG_STAT: nxt_prdata = {30'h0, pin_level, output_flipflop_ff};
      default:  nxt_prdata = '0;
    endcase
  end

  // answer registers, loaded in the first access cycle so they stand in the ready cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else if (apb_req.psel && apb_req.penable && apb_st_ff == APB_WAIT) begin
      prdata_ff  <= apb_req.pwrite ? '0 : nxt_prdata;
      pslverr_ff <= ~addr_ok;
    end else if (rd_en || wr_en) begin
      prdata_ff  <= '0; // answer stands in the ready cycle only
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end
  end

  // run register: clearing both bits stops counting and buffering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff               <= 1'b0;
      prescaler_run_bit_ff <= 1'b0;
      rde_ff               <= 1'b0;
    end else if (wr_en && apb_req.paddr == REG_RUN) begin
      run_ff               <= wb[RUN_BIT];
      prescaler_run_bit_ff <= wb[PRUN_BIT];
      rde_ff               <= wb[RDE_BIT];
    end
  end

  // mode register: clock source, clear enable, capture trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_ff  <= clk_sel_e'(CLK_RST);
      clr_en_ff   <= 1'b0;
      cap_trig_ff <= cap_trig_e'(CPM_RST);
    end else if (wr_en && apb_req.paddr == REG_MOD) begin
      clk_sel_ff  <= clk_sel_e'(wb[MOD_CLK_LSB +: 2]);
      clr_en_ff   <= wb[MOD_CLE_BIT];
      cap_trig_ff <= cap_trig_e'(wb[MOD_CPM_LSB +: 2]);
    end
  end

  // flop control register: toggle trigger enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_a_ff   <= 1'b0;
      en_b_ff   <= 1'b0;
      en_cap_ff <= 1'b0;
    end else if (wr_en && apb_req.paddr == REG_FFCR) begin
      en_a_ff   <= wb[FFCR_EA_BIT];
      en_b_ff   <= wb[FFCR_EB_BIT];
      en_cap_ff <= wb[FFCR_CAP_BIT];
    end
  end

  // compare b sets the period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_reg_b_ff <= CNT_RST;
    end else if (wr_en && apb_req.paddr == REG_RGB) begin
      compare_reg_b_ff <= wh;
    end
  end

  // compare a buffer always takes writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_a_ff <= CNT_RST;
    end else if (wr_en && apb_req.paddr == REG_RGA) begin
      buffer_a_ff <= wh;
    end
  end

  // compare a: direct write, or reload from the buffer on a b match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_reg_a_ff <= CNT_RST;
    end else if (rde_ff && match_b) begin
      compare_reg_a_ff <= buffer_a_ff;
    end else if (!rde_ff && wr_en && apb_req.paddr == REG_RGA) begin
      compare_reg_a_ff <= wh;
    end
  end

  // up-counter: stop clears, b match may clear one cycle later, else wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_counter_ff <= CNT_RST;
      moved_ff      <= 1'b0;
      clr_pend_ff   <= 1'b0;
    end else if (!run_ff) begin
      up_counter_ff <= CNT_RST;
      moved_ff      <= 1'b0;
      clr_pend_ff   <= 1'b0;
    end else if (clr_pend_ff) begin
      up_counter_ff <= CNT_RST;
      moved_ff      <= 1'b1;
      clr_pend_ff   <= 1'b0;
    end else begin
      up_counter_ff <= count_tick ? up_counter_ff + 1'b1 : up_counter_ff;
      moved_ff      <= count_tick;
      clr_pend_ff   <= match_b & clr_en_ff;
    end
  end

  // capture register a: software command or trigger edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_reg_a_ff <= CNT_RST;
    end else if (capture_now) begin
      capture_reg_a_ff <= up_counter_ff;
    end
  end

  // toggle sources combine by parity so two coincident toggles cancel
  assign toggle_req = (match_a & en_a_ff)
                    ^ (match_b & en_b_ff)
                    ^ (capture_now & en_cap_ff);
  assign ff_cmd = (wr_en && apb_req.paddr == REG_FFCR)
                  ? ff_ctl_e'(wb[FFCR_CTL_LSB +: 2]) : FF_HOLD;

  // software command wins over hardware toggles in the same cycle
  always_comb begin
    nxt_ff = output_flipflop_ff ^ toggle_req;
    unique case (ff_cmd)
      FF_TOGGLE: nxt_ff = ~output_flipflop_ff;
      FF_SET:    nxt_ff = 1'b1;
      FF_CLEAR:  nxt_ff = 1'b0;
      FF_HOLD:   nxt_ff = output_flipflop_ff ^ toggle_req;
    endcase
  end

  // output flop keeps its level across start, which fixes the polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_flipflop_ff <= 1'b0;
    end else begin
      output_flipflop_ff <= nxt_ff;
    end
  end

  // interrupt pulses, one cycle each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_a_ff   <= 1'b0;
      irq_b_ff   <= 1'b0;
      irq_cap_ff <= 1'b0;
    end else begin
      irq_a_ff   <= match_a;
      irq_b_ff   <= match_b;
      irq_cap_ff <= hw_cap;
    end
  end

  // ports straight from flops
  assign prdata           = prdata_ff;
  assign pready           = (apb_st_ff == APB_DONE);
  assign pslverr          = pslverr_ff;
  assign pulse_output_pin = output_flipflop_ff;
  assign compare_a_irq    = irq_a_ff;
  assign compare_b_irq    = irq_b_ff;
  assign capture_a_irq    = irq_cap_ff;

endmodule

/* File: testbench/timer16_chk.sv */
// Purpose: port-level checks of bus timing, flop commands and event pulses
// Assumes: one clock domain; sees only the top ports
// Notes: bound from the testbench top file
`timescale 1ns/1ps
module timer16_chk
  import timer16_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire apb_req_s          apb_req,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              ext_count_trigger_in,
  input wire logic              pulse_output_pin,
  input wire logic              compare_a_irq,
  input wire logic              compare_b_irq,
  input wire logic              capture_a_irq
);
  logic       ffcr_wr;
  logic [1:0] ffcr_code;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // completed write to the flop control register and its command code
  assign ffcr_wr   = apb_req.psel & apb_req.penable & pready & apb_req.pwrite
                     & (apb_req.paddr == REG_FFCR);
  assign ffcr_code = apb_req.pwdata[1:0];

  a_setup_ready: assert property (apb_req.psel && !apb_req.penable |=> !pready ##1 pready)
    else $error("access not answered after one wait state");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready && apb_req.psel && apb_req.penable)
    else $error("error flag outside a completing access");
  a_rdata_idle: assert property (!pready |-> prdata == '0)
    else $error("read data not zero outside the ready cycle");
  a_ff_clear: assert property (ffcr_wr && ffcr_code == FF_CLEAR |=> !pulse_output_pin)
    else $error("clear command did not clear the output");
  a_ff_set: assert property (ffcr_wr && ffcr_code == FF_SET |=> pulse_output_pin)
    else $error("set command did not set the output");
  a_ff_toggle: assert property (ffcr_wr && ffcr_code == FF_TOGGLE
    |=> pulse_output_pin != $past(pulse_output_pin))
    else $error("toggle command did not flip the output");
  a_irqa_single: assert property (compare_a_irq |=> !compare_a_irq)
    else $error("compare a event longer than one cycle");
  a_irqb_single: assert property (compare_b_irq |=> !compare_b_irq)
    else $error("compare b event longer than one cycle");
  a_cap_synced: assert property (capture_a_irq
    |-> $past(ext_count_trigger_in, 3) || $past(ext_count_trigger_in, 4))
    else $error("capture event without a synchronised pin edge");
endmodule

/* File: testbench/ext_pin_model.sv */
// Purpose: far-side model: drives the count/trigger pin, watches the pulse pin
// Assumes: pin pulses last at least two clocks high and two low
// Notes: width argument gives prompt or slow events
`timescale 1ns/1ps
module ext_pin_model (
  input  wire logic pclk,
  input  wire logic pulse_output_pin,
  output logic      ext_count_trigger_in
);
  int   rises;
  logic last_ff;

  initial begin
    ext_count_trigger_in = 1'b0;
    rises = 0;
    last_ff = 1'b0;
  end

  // count rising edges of the pulse output
  always @(posedge pclk) begin
    if (pulse_output_pin === 1'b1 && last_ff === 1'b0) rises <= rises + 1;
    last_ff <= pulse_output_pin;
  end

  // n active-high events, w clocks high then w clocks low
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      ext_count_trigger_in <= 1'b1;
      repeat (w) @(posedge pclk);
      ext_count_trigger_in <= 1'b0;
      repeat (w) @(posedge pclk);
    end
  endtask
endmodule

/* File: testbench/timer16_event_ppg_oneshot_tb.sv */
// Purpose: self-checking bench for event count, pulse and one-shot modes
// Assumes: one wait state per access; prescaler /2 tap ticks every 2 clocks
// Notes: far-side pin driven by ext_pin_model
`timescale 1ns/1ps
module timer16_event_ppg_oneshot_tb import timer16_pkg::*;;
  logic              pclk;
  logic              presetn;
  apb_req_s          req;
  logic [DATA_W-1:0] prdata;
  logic              pready, pslverr, trig, pin, irq_a, irq_b, irq_c;
  logic [2:0]        irqv;
  int                bad_count, cmp_count, cyc_ff;

  assign irqv = {irq_c, irq_b, irq_a};

  timer16_event_ppg_oneshot dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_count_trigger_in(trig),
    .pulse_output_pin(pin), .compare_a_irq(irq_a), .compare_b_irq(irq_b),
    .capture_a_irq(irq_c));
  ext_pin_model src (.pclk(pclk), .pulse_output_pin(pin), .ext_count_trigger_in(trig));

  // clock and cycle count
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc_ff <= cyc_ff + 1;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one bus transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge pclk);
    req.penable <= 1'b1;
    // no cycle count assumed; the watchdog ends a hung access
    do begin @(posedge pclk); end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(nm, q, x);
  endtask

  task automatic wait_irq(input int k, input int lim, output int c);
    c = 0;
    do begin @(posedge pclk); c++; end while (irqv[k] !== 1'b1 && c < lim);
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    rdc("run", REG_RUN, 32'h0);
    rdc("mod", REG_MOD, 32'h20);
    rdc("ffcr", REG_FFCR, 32'hC3);
    rdc("cap", REG_CPA, 32'h0);
    rdc("stat", REG_STAT, 32'h0);
    wr(REG_RGB, 32'hFFFF1234);
    rdc("cmpb", REG_RGB, 32'h1234);
    apb(1'b1, 8'h1C, 32'hFF, q, e);
    check("wr_err", 32'(e), 32'h1);
    apb(1'b0, 8'h1C, 32'h0, q, e);
    check("rd_err", 32'(e), 32'h1);
    check("rd_zero", q, 32'h0);
  endtask

  task automatic t_event;
    wr(REG_RUN, 32'h0);
    wr(REG_MOD, 32'h20);
    wr(REG_RUN, 32'h01);
    src.pulses(3, 3);
    wr(REG_MOD, 32'h00);
    rdc("ev_noprun", REG_CPA, 32'h0);
    wr(REG_RUN, 32'h05);
    src.pulses(5, 2);
    wr(REG_MOD, 32'h00);
    rdc("ev_count", REG_CPA, 32'h5);
  endtask

  task automatic t_ffcr;
    logic [1:0] code [4] = '{FF_CLEAR, FF_SET, FF_TOGGLE, FF_HOLD};
    logic       lvl  [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      wr(REG_FFCR, {30'h0, code[i]});
      rdc("ff_cmd", REG_STAT, {31'h0, lvl[i]});
    end
    rdc("ff_rd", REG_FFCR, 32'hC3);
  endtask

  task automatic t_ppg;
    int c;
    for (int p = 0; p < 2; p++) begin
      wr(REG_RUN, 32'h0);
      wr(REG_RGA, 32'h4);
      wr(REG_RGB, 32'hA);
      wr(REG_MOD, 32'h25);
      wr(REG_FFCR, (p == 0) ? 32'hE : 32'hD);
      wr(REG_RUN, 32'h85);
      wait_irq(0, 400, c);
      check("ppg_a_lvl", 32'(pin), 32'(p == 0));
      wait_irq(1, 400, c);
      check("ppg_duty", 32'(c), 32'hC);
      check("ppg_b_lvl", 32'(pin), 32'(p));
      wr(REG_RGA, 32'h6);
      wait_irq(0, 400, c);
      wait_irq(1, 400, c);
      check("buf_hold", 32'(c), 32'hC);
      wait_irq(0, 400, c);
      wait_irq(1, 400, c);
      check("buf_load", 32'(c), 32'h8);
    end
    wr(REG_RUN, 32'h0);
    wait_irq(1, 60, c);
    check("stopped", 32'(c), 32'h3C);
  endtask

  task automatic t_oneshot;
    int          c, t0, r0;
    logic [31:0] cv;
    logic        e;
    wr(REG_RUN, 32'h0);
    wr(REG_MOD, 32'h29);
    wr(REG_FFCR, 32'h2);
    wr(REG_RUN, 32'h05);
    repeat (20) @(posedge pclk);
    r0 = src.rises;
    fork
      src.pulses(1, 4);
      begin wait_irq(2, 40, c); t0 = cyc_ff; end
    join
    check("trig_seen", 32'(c < 40), 32'h1);
    apb(1'b0, REG_CPA, 32'h0, cv, e);
    wr(REG_RGA, cv + 32'h1E);
    wr(REG_RGB, cv + 32'h28);
    wr(REG_FFCR, 32'hF);
    wait_irq(0, 200, c);
    check("os_delay", 32'(cyc_ff - t0 >= 55 && cyc_ff - t0 <= 65), 32'h1);
    check("os_lead", 32'(pin), 32'h1);
    wait_irq(1, 200, c);
    check("os_width", 32'(c), 32'h14);
    check("os_trail", 32'(pin), 32'h0);
    wr(REG_FFCR, 32'h3);
    repeat (100) @(posedge pclk);
    check("os_once", 32'(src.rises - r0), 32'h1);
    wr(REG_FFCR, 32'h12);
    wr(REG_MOD, 32'h09);
    rdc("sw_cap_tgl", REG_STAT, 32'h1);
    fork
      src.pulses(1, 4);
      wait_irq(2, 40, c);
    join
    check("cap_tgl", 32'(pin), 32'h0);
  endtask

  // slower prescaler taps: /8 gives 9 counts and /32 gives 2 in the same window
  task automatic t_taps;
    logic [1:0]  sel [2] = '{2'b10, 2'b11};
    logic [31:0] cnt [2] = '{32'h9, 32'h2};
    for (int i = 0; i < 2; i++) begin
      wr(REG_RUN, 32'h0);
      wr(REG_MOD, {26'h0, 4'h8, sel[i]});
      wr(REG_RUN, 32'h05);
      repeat (73) @(posedge pclk);
      wr(REG_MOD, {30'h0, sel[i]});
      rdc("tap_count", REG_CPA, cnt[i]);
    end
  endtask

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    bad_count = 0;
    cmp_count = 0;
    cyc_ff = 0;
    presetn = 1'b0;
    req = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_event;
    t_ffcr;
    t_ppg;
    t_taps;
    t_oneshot;
    report_and_stop;
  end

  // hang guard
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end
endmodule

bind timer16_event_ppg_oneshot timer16_chk chk (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_count_trigger_in(ext_count_trigger_in), .pulse_output_pin(pulse_output_pin),
  .compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq),
  .capture_a_irq(capture_a_irq));
